//--- mir_regs.sv
// The APB interface to the registers was left to the implementer.
`timescale 1ns/10ps
// Contract
// - management done flag sets when a phy frame ends; status read clears it
// - receive complete flag sets per stored frame; cleared by status read
// - receive owned-descriptor flag sets on used descriptor fetch; read clears
// - transmit owned-descriptor flag sets on used descriptor fetch; read clears
// - underrun flag sets on late fetch, bus error, midframe used, queue write
// - transmit exhausted flag sets when buffers run out midframe; read clears
// - transmit complete flag sets when a frame is sent; read clears
// - receive overrun flag sets when overrun status sets; read clears
// - bus error flag sets on dma error response; read clears
// - pause received flag sets on a valid pause frame; read clears
// - pause zero flag sets when pause count decrements to zero; read clears
// - enable register is write-only; a one unmasks that event
// - disable register is write-only; a one masks that event
// - mask register reads current masked state of every event
// - data field sends write data; read result lands there
// - operation 10 reads, 01 writes, other codes are invalid frames
// - register holds phy address and phy register address fields
// - pause count decrements once every 512 bit times
// - low hash register holds filter bits 31 to 0
// - high hash register holds filter bits 63 to 32
// - idle indication is 0 when idle, 1 while shifting a frame
module mir_regs #(
	parameter int ADDR_W = 8,
	parameter int MDC_HALF = 4,
	parameter int PAUSE_QUANTUM = 512
) (
	// clock and reset
	input wire logic pclk,
	input wire logic presetn,
	// apb slave
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [ADDR_W-1:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	// mac events
	input wire mir_pkg::mir_evt_t evt,
	input wire logic [15:0] pause_value,
	input wire logic bit_tick,
	// management link
	input wire logic mdio_i,
	output mir_pkg::mir_mdio_out_t mdio,
	// status and filter
	output logic irq,
	output logic mgmt_busy,
	output logic [15:0] pause_count,
	output logic [63:0] hash_filter
);

	// ----------------------------------------
	// apb decode
	// ----------------------------------------
	function automatic logic hit(input logic [ADDR_W-1:0] a, input logic [7:0] ofs);
		hit = (a == ADDR_W'(ofs));
	endfunction

	logic pready_r;
	logic pslverr_r;
	logic [31:0] prdata_r;
	logic [13:0] status_r;
	logic [13:0] mask_r;
	logic [31:0] mgmt_r;
	logic [15:0] pause_r;
	logic [31:0] hash_lo_r;
	logic [31:0] hash_hi_r;
	logic irq_r;
	logic busy_r;
	logic mdc_r;
	logic mdio_o_r;
	logic mdio_oe_r;
	logic [5:0] bit_r;
	logic [$clog2(MDC_HALF)-1:0] div_r;
	logic [15:0] rdsh_r;
	logic [$clog2(PAUSE_QUANTUM)-1:0] quant_r;

	wire access = psel & penable;
	wire fire = access & pready_r;
	wire wr_fire = fire & pwrite;
	wire rd_fire = fire & ~pwrite;
	wire h_ns = hit(paddr, mir_pkg::OFS_NET_STATUS);
	wire h_st = hit(paddr, mir_pkg::OFS_EVT_STATUS);
	wire h_es = hit(paddr, mir_pkg::OFS_EVT_EN_SET);
	wire h_ec = hit(paddr, mir_pkg::OFS_EVT_EN_CLR);
	wire h_mk = hit(paddr, mir_pkg::OFS_EVT_MASK);
	wire h_mg = hit(paddr, mir_pkg::OFS_PHY_MGMT);
	wire h_pt = hit(paddr, mir_pkg::OFS_PAUSE);
	wire h_hl = hit(paddr, mir_pkg::OFS_HASH_LO);
	wire h_hh = hit(paddr, mir_pkg::OFS_HASH_HI);
	wire mapped = h_ns | h_st | h_es | h_ec | h_mk | h_mg | h_pt | h_hl | h_hh;
	wire [13:0] wr_bits = pwdata[13:0] & mir_pkg::EVT_VALID;

	// read mux; write-only registers read as zero
	wire [31:0] ns_word = {29'h0000_0000, busy_r, mdio_i, 1'b0};
	wire [31:0] rdata_nxt =
		h_ns ? ns_word :
		h_st ? {18'h0_0000, status_r} :
		h_mk ? {18'h0_0000, mask_r} :
		h_mg ? mgmt_r :
		h_pt ? {16'h0000, pause_r} :
		h_hl ? hash_lo_r :
		h_hh ? hash_hi_r :
		mir_pkg::WORD_ZERO;

	// one wait state so that read data and ready come from flops
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pready_r <= 1'b0;
			pslverr_r <= 1'b0;
			prdata_r <= mir_pkg::WORD_ZERO;
		end else begin
			pready_r <= access & ~pready_r;
			pslverr_r <= access & ~pready_r & ~mapped;
			prdata_r <= (access & ~pready_r) ? rdata_nxt : prdata_r;
		end
	end

	// ----------------------------------------
	// event status, mask and interrupt
	// ----------------------------------------
	wire mg_done;
	wire pause_hit_zero;
	wire [13:0] ev_vec = {
		pause_hit_zero, evt.pause_received, evt.bus_error, evt.rx_overrun,
		2'b00,
		evt.tx_complete, evt.tx_exhausted, evt.retry_limit,
		evt.tx_underrun | evt.tx_queue_written,
		evt.tx_owned_desc, evt.rx_owned_desc, evt.rx_complete, mg_done
	};
	// clear only the bits that went out in the captured read word, so an event
	// landing between capture and completion survives; a new event wins anyway
	wire [13:0] rd_clear = (rd_fire & h_st) ? prdata_r[13:0] : mir_pkg::EVT_NONE;
	wire [13:0] status_nxt = (status_r & ~rd_clear) | ev_vec;
	wire [13:0] mask_nxt = (wr_fire & h_es) ? (mask_r & ~wr_bits) :
		(wr_fire & h_ec) ? (mask_r | wr_bits) : mask_r;
	wire irq_nxt = |(status_r & ~mask_r & mir_pkg::EVT_VALID);

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			status_r <= mir_pkg::EVT_NONE;
			mask_r <= mir_pkg::MASK_RST;
			irq_r <= 1'b0;
		end else begin
			status_r <= status_nxt;
			mask_r <= mask_nxt;
			irq_r <= irq_nxt;
		end
	end

	// ----------------------------------------
	// phy management shifter
	// ----------------------------------------
	// 32 preamble ones then the 32-bit register image msb first; mdc is
	// derived by a divider so it is not a second clock domain
	wire mg_start = wr_fire & h_mg & ~busy_r;
	wire div_tick = busy_r & (div_r == ($clog2(MDC_HALF))'(MDC_HALF - 1));
	wire mdc_fall = div_tick & mdc_r;
	wire mdc_rise = div_tick & ~mdc_r;
	wire op_read = (mgmt_r[mir_pkg::MG_OP_HI:mir_pkg::MG_OP_LO] == mir_pkg::MG_OP_READ);
	wire in_frame = bit_r[5];
	assign mg_done = mdc_fall & (bit_r == mir_pkg::MG_LAST_BIT);
	// release the line for turnaround and data only on a valid read
	wire release_line = op_read & in_frame & (bit_r[4:0] >= mir_pkg::MG_TA_START);
	wire drive_bit = in_frame ? mgmt_r[~bit_r[4:0]] : 1'b1;
	wire sample = mdc_rise & op_read & in_frame & bit_r[4];
	// writes while a frame runs are ignored so the image stays stable
	wire [31:0] mgmt_nxt = mg_start ? pwdata :
		(mg_done & op_read) ? {mgmt_r[31:mir_pkg::MG_DATA_W], rdsh_r} : mgmt_r;

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			mgmt_r <= mir_pkg::MG_RST;
			busy_r <= 1'b0;
			mdc_r <= 1'b0;
			div_r <= '0;
			bit_r <= '0;
			rdsh_r <= 16'h0000;
			mdio_o_r <= 1'b0;
			mdio_oe_r <= 1'b0;
		end else begin
			mgmt_r <= mgmt_nxt;
			busy_r <= mg_start | (busy_r & ~mg_done);
			mdc_r <= div_tick ? ~mdc_r : (busy_r & mdc_r);
			div_r <= (mg_start | div_tick) ? '0 : div_r + 1'b1;
			bit_r <= mg_start ? '0 : (mdc_fall ? bit_r + 1'b1 : bit_r);
			rdsh_r <= sample ? {rdsh_r[14:0], mdio_i} : rdsh_r;
			mdio_o_r <= busy_r & drive_bit;
			mdio_oe_r <= busy_r & ~mg_done & ~release_line;
		end
	end

	// ----------------------------------------
	// pause countdown and hash filter
	// ----------------------------------------
	wire quantum = bit_tick & (quant_r == ($clog2(PAUSE_QUANTUM))'(PAUSE_QUANTUM - 1));
	wire pt_write = wr_fire & h_pt;
	localparam logic [15:0] PAUSE_LAST = 16'h0001;
	wire dec = quantum & (pause_r != mir_pkg::PAUSE_RST) & ~pt_write & ~evt.pause_received;
	assign pause_hit_zero = dec & (pause_r == PAUSE_LAST);
	// software write beats a received pause frame, which beats the countdown
	wire [15:0] pause_nxt = pt_write ? pwdata[15:0] :
		evt.pause_received ? pause_value : (dec ? pause_r - 1'b1 : pause_r);

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pause_r <= mir_pkg::PAUSE_RST;
			quant_r <= '0;
			hash_lo_r <= mir_pkg::HASH_RST;
			hash_hi_r <= mir_pkg::HASH_RST;
		end else begin
			pause_r <= pause_nxt;
			quant_r <= quantum ? '0 : (bit_tick ? quant_r + 1'b1 : quant_r);
			hash_lo_r <= (wr_fire & h_hl) ? pwdata : hash_lo_r;
			hash_hi_r <= (wr_fire & h_hh) ? pwdata : hash_hi_r;
		end
	end

	// output drive, all from flops
	assign prdata = prdata_r;
	assign pready = pready_r;
	assign pslverr = pslverr_r;
	assign irq = irq_r;
	assign mgmt_busy = busy_r;
	assign pause_count = pause_r;
	assign hash_filter = {hash_hi_r, hash_lo_r};
	assign mdio = '{mdc: mdc_r, mdio_o: mdio_o_r, mdio_oe: mdio_oe_r};

	// ----------------------------------------
	// assertions
	// ----------------------------------------
	sequence s_frame_start;
		mg_start;
	endsequence
	sequence s_frame_busy;
		busy_r [*8];
	endsequence

	a_done_sets_flag: assert property (@(posedge pclk) disable iff (!presetn)
		mg_done |=> status_r[mir_pkg::B_MGMT_DONE] && !busy_r)
		else $error("management done did not set its flag");
	a_events_set_flags: assert property (@(posedge pclk) disable iff (!presetn)
		(ev_vec != mir_pkg::EVT_NONE) |=> ((status_r & $past(ev_vec)) == $past(ev_vec)))
		else $error("event pulse lost in status");
	a_underrun_queue: assert property (@(posedge pclk) disable iff (!presetn)
		evt.tx_queue_written |=> status_r[mir_pkg::B_TX_UNDERRUN])
		else $error("queue write did not flag underrun");
	a_read_clears_flags: assert property (@(posedge pclk) disable iff (!presetn)
		(rd_fire && h_st) |=> ((status_r & $past(prdata_r[13:0]) & ~$past(ev_vec)) == mir_pkg::EVT_NONE))
		else $error("status read did not clear flags");
	a_enable_unmasks: assert property (@(posedge pclk) disable iff (!presetn)
		(wr_fire && h_es) |=> ((mask_r & $past(wr_bits)) == mir_pkg::EVT_NONE))
		else $error("enable write left event masked");
	a_disable_masks: assert property (@(posedge pclk) disable iff (!presetn)
		(wr_fire && h_ec) |=> ((mask_r & $past(wr_bits)) == $past(wr_bits)))
		else $error("disable write left event unmasked");
	a_irq_follows: assert property (@(posedge pclk) disable iff (!presetn)
		(status_r[mir_pkg::B_RX_COMPLETE] && !mask_r[mir_pkg::B_RX_COMPLETE]) |=> irq_r)
		else $error("unmasked flag without interrupt");
	a_busy_frame: assert property (@(posedge pclk) disable iff (!presetn)
		s_frame_start |=> s_frame_busy)
		else $error("idle indication dropped during frame");
	a_read_data_lands: assert property (@(posedge pclk) disable iff (!presetn)
		(mg_done && op_read) |=> (mgmt_r[15:0] == $past(rdsh_r)))
		else $error("phy read data not stored");
	a_pause_decrement: assert property (@(posedge pclk) disable iff (!presetn)
		dec |=> (pause_r == $past(pause_r) - 16'h0001))
		else $error("pause count did not decrement");
	a_pause_zero_flag: assert property (@(posedge pclk) disable iff (!presetn)
		(dec && pause_r == 16'h0001) |=> (pause_r == 16'h0000) && status_r[mir_pkg::B_PAUSE_ZERO])
		else $error("pause zero not flagged");

	// ----------------------------------------
	// per-event flag assertions
	// ----------------------------------------
	a_rx_done_flag: assert property (@(posedge pclk) disable iff (!presetn)
		evt.rx_complete |=> status_r[mir_pkg::B_RX_COMPLETE])
		else $error("receive complete not flagged");
	a_rx_owned_flag: assert property (@(posedge pclk) disable iff (!presetn)
		evt.rx_owned_desc |=> status_r[mir_pkg::B_RX_OWNED])
		else $error("receive owned descriptor not flagged");
	a_tx_owned_flag: assert property (@(posedge pclk) disable iff (!presetn)
		evt.tx_owned_desc |=> status_r[mir_pkg::B_TX_OWNED])
		else $error("transmit owned descriptor not flagged");
	a_underrun_flag: assert property (@(posedge pclk) disable iff (!presetn)
		evt.tx_underrun |=> status_r[mir_pkg::B_TX_UNDERRUN])
		else $error("underrun not flagged");
	a_exhausted_flag: assert property (@(posedge pclk) disable iff (!presetn)
		evt.tx_exhausted |=> status_r[mir_pkg::B_TX_EXHAUSTED])
		else $error("transmit exhausted not flagged");
	a_tx_done_flag: assert property (@(posedge pclk) disable iff (!presetn)
		evt.tx_complete |=> status_r[mir_pkg::B_TX_COMPLETE])
		else $error("transmit complete not flagged");
	a_overrun_flag: assert property (@(posedge pclk) disable iff (!presetn)
		evt.rx_overrun |=> status_r[mir_pkg::B_RX_OVERRUN])
		else $error("receive overrun not flagged");
	a_bus_err_flag: assert property (@(posedge pclk) disable iff (!presetn)
		evt.bus_error |=> status_r[mir_pkg::B_BUS_ERROR])
		else $error("bus error not flagged");
	a_pause_rx_flag: assert property (@(posedge pclk) disable iff (!presetn)
		evt.pause_received |=> status_r[mir_pkg::B_PAUSE_RX])
		else $error("pause frame not flagged");
	a_retry_flag: assert property (@(posedge pclk) disable iff (!presetn)
		evt.retry_limit |=> status_r[mir_pkg::B_RETRY_LIMIT])
		else $error("retry limit not flagged");
	a_status_holds: assert property (@(posedge pclk) disable iff (!presetn)
		(rd_clear == mir_pkg::EVT_NONE && ev_vec == mir_pkg::EVT_NONE) |=> (status_r == $past(status_r)))
		else $error("status changed without event or read");
	a_status_reserved: assert property (@(posedge pclk) disable iff (!presetn)
		(status_r & ~mir_pkg::EVT_VALID) == mir_pkg::EVT_NONE)
		else $error("reserved status bit set");

	// ----------------------------------------
	// mask, interrupt, bus and hash assertions
	// ----------------------------------------
	a_mask_reserved: assert property (@(posedge pclk) disable iff (!presetn)
		(mask_r & ~mir_pkg::EVT_VALID) == mir_pkg::EVT_NONE)
		else $error("reserved mask bit set");
	a_mask_holds: assert property (@(posedge pclk) disable iff (!presetn)
		!(wr_fire && (h_es || h_ec)) |=> (mask_r == $past(mask_r)))
		else $error("mask changed without a write");
	a_irq_any: assert property (@(posedge pclk) disable iff (!presetn)
		((status_r & ~mask_r & mir_pkg::EVT_VALID) != mir_pkg::EVT_NONE) |=> irq_r)
		else $error("unmasked flag without interrupt");
	a_irq_quiet: assert property (@(posedge pclk) disable iff (!presetn)
		((status_r & ~mask_r & mir_pkg::EVT_VALID) == mir_pkg::EVT_NONE) |=> !irq_r)
		else $error("interrupt without unmasked flag");
	a_ready_pulse: assert property (@(posedge pclk) disable iff (!presetn)
		pready_r |=> !pready_r)
		else $error("ready stood longer than one cycle");
	a_slverr_pair: assert property (@(posedge pclk) disable iff (!presetn)
		pslverr_r |-> pready_r)
		else $error("slave error without ready");
	a_hash_low_hold: assert property (@(posedge pclk) disable iff (!presetn)
		!(wr_fire && h_hl) |=> (hash_lo_r == $past(hash_lo_r)))
		else $error("low hash changed without a write");
	a_hash_high_hold: assert property (@(posedge pclk) disable iff (!presetn)
		!(wr_fire && h_hh) |=> (hash_hi_r == $past(hash_hi_r)))
		else $error("high hash changed without a write");

	// ----------------------------------------
	// pause and management assertions
	// ----------------------------------------
	a_pause_load: assert property (@(posedge pclk) disable iff (!presetn)
		(evt.pause_received && !pt_write) |=> (pause_r == $past(pause_value)))
		else $error("pause value not loaded");
	a_pause_hold: assert property (@(posedge pclk) disable iff (!presetn)
		(!dec && !pt_write && !evt.pause_received) |=> (pause_r == $past(pause_r)))
		else $error("pause count moved without cause");
	a_zero_no_dec: assert property (@(posedge pclk) disable iff (!presetn)
		(pause_r == mir_pkg::PAUSE_RST) |-> !dec)
		else $error("pause count decremented below zero");
	a_start_clears: assert property (@(posedge pclk) disable iff (!presetn)
		mg_start |=> busy_r && (bit_r == '0))
		else $error("frame start did not reset the bit count");
	a_shift_count: assert property (@(posedge pclk) disable iff (!presetn)
		(mdc_fall && !mg_start) |=> (bit_r == $past(bit_r) + 6'h01))
		else $error("bit count did not advance on mdc fall");
	a_image_stable: assert property (@(posedge pclk) disable iff (!presetn)
		(busy_r && !mg_done) |=> (mgmt_r == $past(mgmt_r)))
		else $error("management image changed mid frame");
	a_write_drives: assert property (@(posedge pclk) disable iff (!presetn)
		(busy_r && !op_read && !mg_done) |=> mdio_oe_r)
		else $error("line released during a write frame");
	a_read_release: assert property (@(posedge pclk) disable iff (!presetn)
		(busy_r && op_read && in_frame && bit_r[4]) |=> !mdio_oe_r)
		else $error("line driven during read data");
	a_idle_quiet: assert property (@(posedge pclk) disable iff (!presetn)
		!busy_r |-> !mdc_r)
		else $error("mdc high while idle");
	a_busy_ends: assert property (@(posedge pclk) disable iff (!presetn)
		mg_done |=> !mdio_oe_r && !mdc_r)
		else $error("link not released after frame");

endmodule

//--- mir_pkg.sv
package mir_pkg;

	// ----------------------------------------
	// register byte offsets
	// ----------------------------------------
	localparam logic [7:0] OFS_NET_STATUS = 8'h08;
	localparam logic [7:0] OFS_EVT_STATUS = 8'h24;
	localparam logic [7:0] OFS_EVT_EN_SET = 8'h28;
	localparam logic [7:0] OFS_EVT_EN_CLR = 8'h2c;
	localparam logic [7:0] OFS_EVT_MASK = 8'h30;
	localparam logic [7:0] OFS_PHY_MGMT = 8'h34;
	localparam logic [7:0] OFS_PAUSE = 8'h38;
	localparam logic [7:0] OFS_HASH_LO = 8'h90;
	localparam logic [7:0] OFS_HASH_HI = 8'h94;

	// ----------------------------------------
	// event vector layout
	// ----------------------------------------
	localparam int EVT_W = 14;
	localparam int B_MGMT_DONE = 0;
	localparam int B_RX_COMPLETE = 1;
	localparam int B_RX_OWNED = 2;
	localparam int B_TX_OWNED = 3;
	localparam int B_TX_UNDERRUN = 4;
	localparam int B_RETRY_LIMIT = 5;
	localparam int B_TX_EXHAUSTED = 6;
	localparam int B_TX_COMPLETE = 7;
	localparam int B_RX_OVERRUN = 10;
	localparam int B_BUS_ERROR = 11;
	localparam int B_PAUSE_RX = 12;
	localparam int B_PAUSE_ZERO = 13;
	localparam logic [13:0] EVT_VALID = 14'h3cff;
	localparam logic [13:0] MASK_RST = 14'h3cff;
	localparam logic [13:0] EVT_NONE = 14'h0000;

	// ----------------------------------------
	// network status and phy management fields
	// ----------------------------------------
	localparam int NS_MDIO_BIT = 1;
	localparam int NS_IDLE_BIT = 2;
	localparam int MG_OP_HI = 29;
	localparam int MG_OP_LO = 28;
	localparam int MG_DATA_W = 16;
	localparam logic [1:0] MG_OP_READ = 2'b10;
	localparam logic [1:0] MG_OP_WRITE = 2'b01;
	localparam logic [5:0] MG_LAST_BIT = 6'h3f;
	localparam logic [4:0] MG_TA_START = 5'h0e;
	localparam logic [31:0] MG_RST = 32'h0000_0000;
	localparam logic [15:0] PAUSE_RST = 16'h0000;
	localparam logic [31:0] HASH_RST = 32'h0000_0000;
	localparam logic [31:0] WORD_ZERO = 32'h0000_0000;

	// event pulses from the mac datapath and dma
	typedef struct packed {
		logic rx_complete;
		logic rx_owned_desc;
		logic tx_owned_desc;
		logic tx_underrun;
		logic tx_queue_written;
		logic retry_limit;
		logic tx_exhausted;
		logic tx_complete;
		logic rx_overrun;
		logic bus_error;
		logic pause_received;
	} mir_evt_t;

	// management link outputs
	typedef struct packed {
		logic mdc;
		logic mdio_o;
		logic mdio_oe;
	} mir_mdio_out_t;

endpackage

//--- mir_phy_model.sv
`timescale 1ns/10ps
// ----------------------------------------
// management link partner
// ----------------------------------------
module mir_phy_model #(
	parameter logic [15:0] RD_DATA = 16'ha5c3
) (
	// link as seen on the wire
	input wire logic mdc,
	input wire logic line,
	// phy drive
	output logic p_oe,
	output logic p_o,
	// last complete frame
	output logic [31:0] frame
);
	int ones;
	int pos;
	logic infr;
	logic [31:0] sh;
	initial begin
		ones = 0;
		pos = 0;
		infr = 0;
		p_oe = 0;
		p_o = 1;
		frame = '0;
	end
	// a frame starts at the first zero after at least 32 preamble ones
	always @(posedge mdc) begin
		if (!infr) begin
			if (!line && ones >= 32) begin
				infr = 1;
				pos = 1;
				sh = {31'h0, line};
			end
			ones = line ? ones + 1 : 0;
		end else begin
			sh = {sh[30:0], line};
			pos++;
			if (pos == 32) begin
				infr = 0;
				frame = sh;
				ones = 0;
			end
		end
	end
	// read data changes after mdc falls; when not driving, p_o toggles while p_oe stays low
	always @(negedge mdc) begin
		if (infr && pos >= 16 && {sh[pos-3], sh[pos-4]} == 2'b10) begin
			p_oe <= 1'b1;
			p_o <= RD_DATA[31-pos];
		end else begin
			p_oe <= 1'b0;
			p_o <= ~p_o;
		end
	end
endmodule

//--- mir_regs_test.sv
`timescale 1ns/10ps
// ----------------------------------------
// bench for the event and management registers
// ----------------------------------------
module mir_regs_test;
	localparam logic [15:0] PHY_DATA = 16'ha5c3;
	logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, bit_tick = 0;
	logic [7:0] paddr = '0;
	logic [31:0] pwdata = '0, prdata, w, x, seed = 32'h474e;
	logic pready, pslverr, irq, mgmt_busy, p_oe, p_o;
	mir_pkg::mir_evt_t evt = '0;
	logic [15:0] pause_value = '0, pause_count;
	logic [63:0] hash_filter;
	mir_pkg::mir_mdio_out_t mdio;
	wire mdio_i;
	logic [31:0] frame;
	logic [32:0] expq[$];
	int failures = 0, checked = 0;
	int evt_bit[11] = '{12, 11, 10, 7, 6, 5, 4, 4, 3, 2, 1};
	always #50 pclk = ~pclk;
	// idle line sits at its pull-up level
	assign mdio_i = mdio.mdio_oe ? mdio.mdio_o : (p_oe ? p_o : 1'b1);
	mir_regs #(.ADDR_W(8), .MDC_HALF(2), .PAUSE_QUANTUM(4)) dut (.pclk(pclk), .presetn(presetn), .psel(psel),
		.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .evt(evt), .pause_value(pause_value), .bit_tick(bit_tick), .mdio_i(mdio_i),
		.mdio(mdio), .irq(irq), .mgmt_busy(mgmt_busy), .pause_count(pause_count), .hash_filter(hash_filter));
	mir_phy_model #(.RD_DATA(PHY_DATA)) phy (.mdc(mdio.mdc), .line(mdio_i), .p_oe(p_oe), .p_o(p_o), .frame(frame));
	function automatic logic [31:0] xs(input logic [31:0] s);
		s = s ^ (s << 13);
		s = s ^ (s >> 17);
		return s ^ (s << 5);
	endfunction
	task chk(input logic [32:0] got, input logic [32:0] exp);
		checked++;
		if (got !== exp) begin
			failures++;
			$display("mismatch at %0t got %h expected %h", $time, got, exp);
		end
	endtask
	// read answers are compared with the oldest note taken by the driver
	always @(posedge pclk) begin
		if (psel && penable && pready === 1'b1 && !pwrite && expq.size() > 0) chk({pslverr, prdata}, expq.pop_front());
	end
	// one transfer; held until pready is seen high at a rising edge
	task apb(input logic wr, input logic [7:0] a, input logic [31:0] d, input logic [32:0] e);
		int n;
		@(posedge pclk);
		psel <= 1;
		penable <= 0;
		pwrite <= wr;
		paddr <= a;
		pwdata <= d;
		if (!wr) expq.push_back(e);
		@(posedge pclk);
		penable <= 1;
		n = 0;
		do begin
			@(posedge pclk);
			n++;
		end while (pready !== 1'b1 && n < 50);
		if (pready !== 1'b1) failures++;
		psel <= 0;
		penable <= 0;
	endtask
	task rd(input logic [7:0] a, input logic [31:0] e);
		apb(1'b0, a, 32'h0000_0000, {1'b0, e});
	endtask
	task wr(input logic [7:0] a, input logic [31:0] d);
		apb(1'b1, a, d, 33'h0_0000_0000);
	endtask
	task pulse(input logic [10:0] b);
		@(posedge pclk);
		evt <= mir_pkg::mir_evt_t'(b);
		@(posedge pclk);
		evt <= '0;
	endtask
	task wait_idle;
		int n;
		n = 0;
		while (mgmt_busy !== 1'b0 && n < 1000) begin
			@(posedge pclk);
			n++;
		end
		repeat (2) @(posedge pclk);
	endtask
	task give_verdict;
		$display("checked %0d failures %0d", checked, failures);
		if (failures == 0 && checked > 0) $display("No errors found");
		else $display("Errors were found");
		$finish;
	endtask
	// the whole run needs well under this many cycles
	initial begin
		repeat (20000) @(posedge pclk);
		failures++;
		give_verdict();
	end
	// ----------------------------------------
	// main sequence
	// ----------------------------------------
	initial begin
		repeat (5) @(posedge pclk);
		presetn <= 1;
		rd(mir_pkg::OFS_EVT_MASK, 32'h0000_3cff);
		rd(mir_pkg::OFS_EVT_EN_SET, 32'h0000_0000);
		rd(mir_pkg::OFS_EVT_EN_CLR, 32'h0000_0000);
		apb(1'b0, 8'h3c, 32'h0000_0000, 33'h1_0000_0000);
		$display("test reset done");
		for (int i = 0; i < 11; i++) begin
			pulse(11'(1 << i));
			rd(mir_pkg::OFS_EVT_STATUS, 32'h1 << evt_bit[i]);
			rd(mir_pkg::OFS_EVT_STATUS, 32'h0000_0000);
			chk({32'h0, irq}, 33'h0);
		end
		$display("test event flags done");
		wr(mir_pkg::OFS_EVT_EN_SET, 32'h0000_3cff);
		rd(mir_pkg::OFS_EVT_MASK, 32'h0000_0000);
		wr(mir_pkg::OFS_EVT_EN_CLR, 32'h0000_0002);
		rd(mir_pkg::OFS_EVT_MASK, 32'h0000_0002);
		pulse(11'h408);
		repeat (3) @(posedge pclk);
		chk({32'h0, irq}, 33'h1);
		rd(mir_pkg::OFS_EVT_STATUS, 32'h0000_0082);
		repeat (3) @(posedge pclk);
		chk({32'h0, irq}, 33'h0);
		pulse(11'h400);
		repeat (3) @(posedge pclk);
		chk({32'h0, irq}, 33'h0);
		rd(mir_pkg::OFS_EVT_STATUS, 32'h0000_0002);
		$display("test masking done");
		pause_value <= 16'h0005;
		pulse(11'h001);
		rd(mir_pkg::OFS_PAUSE, 32'h0000_0005);
		rd(mir_pkg::OFS_EVT_STATUS, 32'h0000_1000);
		wr(mir_pkg::OFS_PAUSE, 32'h0000_0003);
		rd(mir_pkg::OFS_PAUSE, 32'h0000_0003);
		bit_tick <= 1;
		repeat (24) @(posedge pclk);
		bit_tick <= 0;
		chk({17'h0, pause_count}, 33'h0);
		rd(mir_pkg::OFS_EVT_STATUS, 32'h0000_2000);
		$display("test pause done");
		w = xs(seed);
		x = xs(w);
		seed = x;
		wr(mir_pkg::OFS_HASH_LO, w);
		wr(mir_pkg::OFS_HASH_HI, x);
		rd(mir_pkg::OFS_HASH_LO, w);
		rd(mir_pkg::OFS_HASH_HI, x);
		chk({1'b0, hash_filter[31:0]}, {1'b0, w});
		chk({1'b0, hash_filter[63:32]}, {1'b0, x});
		$display("test hash done");
		seed = xs(seed);
		w = {4'b0101, seed[27:18], 2'b10, seed[15:0]};
		wr(mir_pkg::OFS_PHY_MGMT, w);
		repeat (2) @(posedge pclk);
		chk({32'h0, mgmt_busy}, 33'h1);
		wait_idle();
		chk({1'b0, frame}, {1'b0, w});
		rd(mir_pkg::OFS_NET_STATUS, 32'h0000_0002);
		rd(mir_pkg::OFS_EVT_STATUS, 32'h0000_0001);
		rd(mir_pkg::OFS_PHY_MGMT, w);
		$display("test phy write done");
		w = {4'b0110, seed[27:18], 2'b10, 16'h0000};
		wr(mir_pkg::OFS_PHY_MGMT, w);
		wr(mir_pkg::OFS_PHY_MGMT, 32'h5002_0000);
		wait_idle();
		chk({1'b0, frame & 32'hfffc_ffff}, {1'b0, w[31:18], 2'b00, PHY_DATA});
		rd(mir_pkg::OFS_PHY_MGMT, {w[31:16], PHY_DATA});
		rd(mir_pkg::OFS_EVT_STATUS, 32'h0000_0001);
		$display("test phy read done");
		w = {4'b0100, seed[27:18], 2'b10, seed[15:0]};
		wr(mir_pkg::OFS_PHY_MGMT, w);
		repeat (2) @(posedge pclk);
		wait_idle();
		chk({1'b0, frame}, {1'b0, w});
		rd(mir_pkg::OFS_PHY_MGMT, w);
		$display("test invalid op done");
		give_verdict();
	end
endmodule
